// *** hw/csb_pkg.sv ***
// Shared constants for the memory-side burst counter of the cache data SRAM.
// Assumes an 8-entry line buffer and at most eight transfers per line.
package csb_pkg;

    // =====================================================================
    // Widths and depths
    localparam int DATA_W = 8;
    localparam int PTR_W = 3;
    localparam int DEPTH = 8;

    // =====================================================================
    // Burst counter values
    localparam logic [PTR_W-1:0] PTR_RST = 3'h0;
    localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;
    localparam logic [PTR_W-1:0] MASK_FOUR = 3'h3;
    localparam logic [PTR_W-1:0] MASK_EIGHT = 3'h7;

    // =====================================================================
    // Bit positions of the synchronised pin vector (system clock side)
    localparam int PIN_SEL = 0;
    localparam int PIN_ISTB = 1;
    localparam int PIN_OSTB = 2;
    localparam int PIN_ZBT = 3;
    localparam int PIN_EOC = 4;
    localparam int PIN_MODE = 5;
    localparam int PIN_DATA = 6;

    // =====================================================================
    // Bit positions of the configuration vector (memory clock side)
    localparam int CFG_START = 0;
    localparam int CFG_EIGHT = 3;
    localparam int CFG_WBSEL = 4;
    localparam int CFG_CLKD = 5;
    localparam int CFG_LCLK = 6;
    localparam int CFG_W = 7;

    // =====================================================================
    // Mode detection: edges seen on the mode pin before clocked mode
    localparam logic [2:0] MODE_EDGES = 3'h4;
    localparam logic [2:0] MODE_CNT_RST = 3'h0;
    localparam logic [2:0] MODE_CNT_ONE = 3'h1;

endpackage : csb_pkg

// *** hw/csb_ctr_if.sv ***
// Control and status bundle between a domain's sequencing logic and its
// burst counter. Assumes both ends sit on the same clock.
`timescale 1ns/10ps
`default_nettype none

interface csb_ctr_if;
    import csb_pkg::*;

    logic init;
    logic zero;
    logic step;
    logic [PTR_W-1:0] start;
    logic eight;
    logic [PTR_W-1:0] ptr;
    logic [PTR_W-1:0] count;

    modport ctl (output init, output zero, output step, output start,
                 output eight, input ptr, input count);
    modport ctr (input init, input zero, input step, input start,
                 input eight, output ptr, output count);
endinterface : csb_ctr_if

`default_nettype wire

// *** hw/csb_burst_ctr.sv ***
// Memory burst counter: walks the processor burst order from a base.
// Assumes init and step come from logic on the same clock as clk_i.
`timescale 1ns/10ps
`default_nettype none

module csb_burst_ctr
    import csb_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    csb_ctr_if.ctr cif
);

    logic [PTR_W-1:0] count_reg;
    logic [PTR_W-1:0] base_reg;
    logic [PTR_W-1:0] mask;

    // Four-transfer lines only use the low two pointer bits
    assign mask = cif.eight ? MASK_EIGHT : MASK_FOUR;

    // =====================================================================
    // Transfer count; init wins over a step in the same cycle
    // count saturates at line end
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            count_reg <= PTR_RST;
        end else if (cif.init) begin
            count_reg <= PTR_RST;
        end else if (cif.step && (count_reg != mask)) begin
            count_reg <= count_reg + PTR_ONE;
        end
    end

    // =====================================================================
    // Starting address of the burst
    // restore original start
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            base_reg <= PTR_RST;
        end else if (cif.init) begin
            base_reg <= cif.zero ? PTR_RST : (cif.start & mask);
        end
    end

    assign cif.ptr = (base_reg ^ count_reg) & mask;
    assign cif.count = count_reg;

    // =====================================================================
    // Checks
    a_zero_start: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (cif.init && cif.zero) |=> (cif.ptr == PTR_RST))
        else $error("zero-based init did not start at zero");

    a_burst_step: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (!cif.init && cif.step && (count_reg != mask) && $stable(cif.eight))
        |=> ((count_reg - $past(count_reg)) == PTR_ONE))
        else $error("burst counter did not advance by one");

    a_count_sat: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (!cif.init && (count_reg == mask) && $stable(cif.eight))
        |=> (count_reg == $past(count_reg)))
        else $error("burst counter moved past line end");

endmodule : csb_burst_ctr

`default_nettype wire

// *** hw/csb_burst_top.sv ***
// Memory-bus burst counter and buffer pointer of a cache data SRAM slice.
// Assumes a memory bus controller drives select, strobes and ready, and
// that the buffers are loaded or read only while no transfer is running.
`timescale 1ns/10ps
`default_nettype none

module csb_burst_top
    import csb_pkg::*;
#(
    parameter int DW = DATA_W
)(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic mem_clk_i,
    input wire logic strobed_mode_select_i,
    input wire logic mem_buffer_select_n_i,
    input wire logic mem_ready_n_i,
    input wire logic mem_input_strobe_i,
    input wire logic mem_output_strobe_i,
    input wire logic mem_output_latch_clock_i,
    input wire logic zero_based_transfer_n_i,
    input wire logic mem_end_of_cycle_n_i,
    input wire logic [DW-1:0] mem_data_i,
    input wire logic [PTR_W-1:0] burst_start_i,
    input wire logic eight_transfers_i,
    input wire logic wb_buf_sel_i,
    input wire logic wb_wr_en_i,
    input wire logic [PTR_W-1:0] wb_wr_addr_i,
    input wire logic [DW-1:0] wb_wr_data_i,
    input wire logic [PTR_W-1:0] cyc_rd_addr_i,
    output wire logic [DW-1:0] mem_data_o,
    output var logic [DW-1:0] cyc_rd_data_o,
    output var logic [PTR_W-1:0] burst_ptr_o,
    output var logic clocked_mode_o
);

    localparam int SYNC_W = PIN_DATA + DW;

    // =====================================================================
    // Buffers: cycle buffer fills from memory, writeback buffer from the
    // user side; both are read by the memory side
    logic [DW-1:0] cyc_buf [0:DEPTH-1];
    logic [DW-1:0] wb_buf [0:DEPTH-1];

    csb_ctr_if sif ();
    csb_ctr_if mif ();

    // =====================================================================
    // System clock side: pin synchronisers
    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] pin_s1;
    logic [SYNC_W-1:0] pin_s2;
    logic [SYNC_W-1:0] pin_s3;
    logic [DW-1:0] din_s;

    assign pin_raw = {mem_data_i, strobed_mode_select_i,
                      mem_end_of_cycle_n_i, zero_based_transfer_n_i,
                      mem_output_strobe_i, mem_input_strobe_i,
                      mem_buffer_select_n_i};

    // Two stages, then a third copy that only serves edge detection
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            pin_s1 <= '1;
            pin_s2 <= '1;
            pin_s3 <= '1;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // Data rides the same stages as the strobes, so they stay aligned
    assign din_s = pin_s2[PIN_DATA +: DW];

    // =====================================================================
    // Mode detection
    logic clocked_reg;
    logic [2:0] mode_cnt_reg;
    logic mode_edge;

    assign mode_edge = pin_s3[PIN_MODE] ^ pin_s2[PIN_MODE];

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            mode_cnt_reg <= MODE_CNT_RST;
        end else if (mode_edge && !clocked_reg) begin
            mode_cnt_reg <= mode_cnt_reg + MODE_CNT_ONE;
        end
    end

    // clock seen, clocked mode
    // Sticky until reset: a mode pin that stops does not drop back
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            clocked_reg <= 1'b0;
        end else if (mode_edge && (mode_cnt_reg == MODE_EDGES - MODE_CNT_ONE)) begin
            clocked_reg <= 1'b1;
        end
    end

    // =====================================================================
    // Strobed mode sequencing
    logic strobed;
    logic sel_act;
    logic sel_fall_ev;
    logic sel_rise_ev;
    logic eoc_ev;
    logic istb_ev;
    logic ostb_ev;

    assign strobed = !clocked_reg;
    assign sel_act = !pin_s2[PIN_SEL];
    assign sel_fall_ev = pin_s3[PIN_SEL] && !pin_s2[PIN_SEL];
    assign sel_rise_ev = !pin_s3[PIN_SEL] && pin_s2[PIN_SEL];
    assign eoc_ev = pin_s3[PIN_EOC] && !pin_s2[PIN_EOC];
    assign istb_ev = pin_s3[PIN_ISTB] ^ pin_s2[PIN_ISTB];
    assign ostb_ev = pin_s3[PIN_OSTB] ^ pin_s2[PIN_OSTB];

    assign sif.init = strobed && (!sel_act || sel_fall_ev || eoc_ev);
    assign sif.zero = !pin_s2[PIN_ZBT];
    assign sif.step = strobed && sel_act && (istb_ev || ostb_ev);
    assign sif.start = burst_start_i;
    assign sif.eight = eight_transfers_i;

    // reset alone already clears the counter
    csb_burst_ctr u_sys_ctr (
        .clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .cif(sif.ctr)
    );

    // =====================================================================
    // Crossing of clocked-mode captures into the system domain
    logic [PTR_W+DW-1:0] xfer_hold_reg;
    logic xfer_tgl_reg;
    logic xt_s1;
    logic xt_s2;
    logic xt_s3;
    logic xfer_ev;

    // Toggle synchroniser; the held word is stable for a whole memory clock
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            xt_s1 <= 1'b0;
            xt_s2 <= 1'b0;
            xt_s3 <= 1'b0;
        end else begin
            xt_s1 <= xfer_tgl_reg;
            xt_s2 <= xt_s1;
            xt_s3 <= xt_s2;
        end
    end

    assign xfer_ev = xt_s2 ^ xt_s3;

    // =====================================================================
    // Buffer writes
    // input strobe latches data
    always_ff @(posedge sys_clk_i) begin
        if (strobed && sel_act && istb_ev) begin
            cyc_buf[sif.ptr] <= din_s;
        end else if (clocked_reg && xfer_ev) begin
            cyc_buf[xfer_hold_reg[DW +: PTR_W]] <= xfer_hold_reg[DW-1:0];
        end
    end

    // Writeback buffer loads from the user side
    always_ff @(posedge sys_clk_i) begin
        if (wb_wr_en_i) begin
            wb_buf[wb_wr_addr_i] <= wb_wr_data_i;
        end
    end

    // =====================================================================
    // Strobed mode output data
    logic [DW-1:0] out_word;
    logic [DW-1:0] sys_dout_reg;

    assign out_word = wb_buf_sel_i ? wb_buf[sif.ptr] : cyc_buf[sif.ptr];

    // output strobe used in strobed mode only
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            sys_dout_reg <= '0;
        end else if (strobed && sel_act && ostb_ev) begin
            sys_dout_reg <= out_word;
        end
    end

    // =====================================================================
    // User-side status and buffer read
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            burst_ptr_o <= PTR_RST;
        end else if (strobed) begin
            burst_ptr_o <= sif.ptr;
        end else if (xfer_ev) begin
            burst_ptr_o <= xfer_hold_reg[DW +: PTR_W];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            cyc_rd_data_o <= '0;
            clocked_mode_o <= 1'b0;
        end else begin
            cyc_rd_data_o <= cyc_buf[cyc_rd_addr_i];
            clocked_mode_o <= clocked_reg;
        end
    end

    // =====================================================================
    // Memory clock side: reset and configuration synchronisers
    logic mrst_s1;
    logic mem_rstn;
    logic [CFG_W-1:0] cfg_raw;
    logic [CFG_W-1:0] cfg_s1;
    logic [CFG_W-1:0] cfg_s2;
    logic m_clocked;

    // The chain takes the reset level itself, so it needs no reset
    always_ff @(posedge mem_clk_i) begin
        mrst_s1 <= rstn_i;
        mem_rstn <= mrst_s1;
    end

    assign cfg_raw = {mem_output_latch_clock_i, clocked_reg, wb_buf_sel_i,
                      eight_transfers_i, burst_start_i};

    always_ff @(posedge mem_clk_i) begin
        if (!mem_rstn) begin
            cfg_s1 <= '0;
            cfg_s2 <= '0;
        end else begin
            cfg_s1 <= cfg_raw;
            cfg_s2 <= cfg_s1;
        end
    end

    assign m_clocked = cfg_s2[CFG_CLKD];

    // =====================================================================
    // Clocked mode sequencing; select, ready, zero-based and end-of-cycle
    // are synchronous to the memory clock and sampled directly
    // select must be driven each edge
    assign mif.init = m_clocked && (mem_buffer_select_n_i || !mem_end_of_cycle_n_i);
    assign mif.zero = !zero_based_transfer_n_i;
    assign mif.step = m_clocked && !mem_buffer_select_n_i && !mem_ready_n_i;
    assign mif.start = cfg_s2[CFG_START +: PTR_W];
    assign mif.eight = cfg_s2[CFG_EIGHT];

    csb_burst_ctr u_mem_ctr (
        .clk_i(mem_clk_i),
        .rstn_i(mem_rstn),
        .cif(mif.ctr)
    );

    // Capture of read data with its pointer for the system side
    always_ff @(posedge mem_clk_i) begin
        if (!mem_rstn) begin
            xfer_hold_reg <= '0;
            xfer_tgl_reg <= 1'b0;
        end else if (mif.step && !mif.init) begin
            xfer_hold_reg <= {mif.ptr, mem_data_i};
            xfer_tgl_reg <= !xfer_tgl_reg;
        end
    end

    // =====================================================================
    // Clocked mode output data
    // Buffers are read across domains; safe only because they are loaded
    // before select asserts and are not rewritten during the burst
    logic [DW-1:0] mem_word;
    logic [DW-1:0] mem_dout_reg;

    assign mem_word = cfg_s2[CFG_WBSEL] ? wb_buf[mif.ptr] : cyc_buf[mif.ptr];

    // latch clock holds outputs while low
    always_ff @(posedge mem_clk_i) begin
        if (!mem_rstn) begin
            mem_dout_reg <= '0;
        end else if (mif.step && !mif.init && cfg_s2[CFG_LCLK]) begin
            mem_dout_reg <= mem_word;
        end
    end

    // Mode is fixed after detection, so this select never glitches a burst
    assign mem_data_o = clocked_reg ? mem_dout_reg : sys_dout_reg;

    // =====================================================================
    // Checks
    a_sel_rise_init: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (strobed && sel_rise_ev) |=> (sif.count == PTR_RST))
        else $error("select release did not reset the counter");

    a_sel_fall_zero: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (strobed && sel_fall_ev && !pin_s2[PIN_ZBT]) |=> (sif.ptr == PTR_RST))
        else $error("zero-based value not taken at select");

    a_strb_idle: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (strobed && sel_act && !sel_fall_ev && !eoc_ev && !istb_ev && !ostb_ev)
        |=> $stable(sif.count))
        else $error("counter moved without a strobe");

    a_eoc_init: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (strobed && eoc_ev) |=> (sif.count == PTR_RST))
        else $error("end-of-cycle did not reset the counter");

    a_istb_latch: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (strobed && sel_act && istb_ev) |=> (cyc_buf[$past(sif.ptr)] == $past(din_s)))
        else $error("input strobe data not latched");

    a_ostb_drive: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (strobed && sel_act && ostb_ev) |=> (sys_dout_reg == $past(out_word)))
        else $error("output strobe did not drive the item");

    a_mode_detect: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (!clocked_reg && mode_edge && (mode_cnt_reg == MODE_EDGES - MODE_CNT_ONE))
        |=> clocked_reg)
        else $error("clock on mode pin not detected");

    a_clk_sel_init: assert property (
        @(posedge mem_clk_i) disable iff (!mem_rstn)
        (m_clocked && mem_buffer_select_n_i) |=> (mif.count == PTR_RST))
        else $error("clocked deselect did not reset the counter");

    a_clk_ready_hold: assert property (
        @(posedge mem_clk_i) disable iff (!mem_rstn)
        (m_clocked && !mem_buffer_select_n_i && mem_ready_n_i && mem_end_of_cycle_n_i)
        |=> $stable(mif.count))
        else $error("clocked counter moved without ready");

endmodule : csb_burst_top

`default_nettype wire

// *** tb/csb_mbc_model.sv ***
// Memory bus controller model: select, strobes, ready, end-of-cycle, data.
// Assumes sys_clk_i paces strobed edges and mem_clk_i paces clocked beats.
`timescale 1ns/10ps
`default_nettype none

module csb_mbc_model (
    input wire logic sys_clk_i,
    input wire logic mem_clk_i,
    output logic sel_n_o,
    output logic rdy_n_o,
    output logic istb_o,
    output logic ostb_o,
    output logic zbt_n_o,
    output logic eoc_n_o,
    output logic [7:0] data_o
);
    // =====================================================================
    // Idle levels at time zero
    // select always defined
    initial begin
        sel_n_o = 1'b1;
        rdy_n_o = 1'b1;
        istb_o = 1'b0;
        ostb_o = 1'b0;
        zbt_n_o = 1'b1;
        eoc_n_o = 1'b1;
        data_o = 8'h5a;
    end

    // Strobed pins are async; pacing on sys_clk keeps levels over 15 ns
    task automatic sys_wait(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : sys_wait

    task automatic frame_start(input logic zbt_n);
        sel_n_o = 1'b1;
        sys_wait(10);
        zbt_n_o = zbt_n;
        sys_wait(4);
        sel_n_o = 1'b0;
        sys_wait(6);
    endtask : frame_start

    task automatic frame_end;
        sel_n_o = 1'b1;
        data_o = ~data_o; // Released bus never shows the last word
        sys_wait(6);
    endtask : frame_end

    task automatic ostb_edge;
        ostb_o = ~ostb_o;
        sys_wait(8);
    endtask : ostb_edge

    task automatic istb_edge(input logic [7:0] d);
        data_o = d;
        sys_wait(1);
        istb_o = ~istb_o;
        sys_wait(8);
    endtask : istb_edge

    task automatic eoc_pulse;
        eoc_n_o = 1'b0;
        sys_wait(4);
        eoc_n_o = 1'b1;
        sys_wait(4);
    endtask : eoc_pulse

    task automatic beat(input logic sel_n, input logic rdy_n);
        @(posedge mem_clk_i);
        #1;
        sel_n_o = sel_n;
        rdy_n_o = rdy_n;
    endtask : beat
endmodule : csb_mbc_model

`default_nettype wire

// *** tb/cache_sram_memory_burst_counter_bench.sv ***
// Self-checking bench for the memory-side burst counter.
// Assumes the controller model drives every bus pin of the block but the mode pin and output latch clock.
`timescale 1ns/10ps
`default_nettype none

module cache_sram_memory_burst_counter_bench;
    import csb_pkg::*;
    logic sys_clk = 1'b0;
    logic mem_clk = 1'b0;
    logic mclk_en = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] start = 3'h0;
    logic eight = 1'b1;
    logic wb_sel = 1'b0;
    logic wb_en = 1'b0;
    logic [2:0] wb_addr = 3'h0;
    logic [7:0] wb_data = 8'h00;
    logic [2:0] rd_addr = 3'h0;
    wire logic sel_n, rdy_n, istb, ostb, zbt_n, eoc_n, cmode;
    wire logic [7:0] mdi, mdo, cyc_rd;
    wire logic [2:0] bptr;
    int n_mismatch = 0;
    int comparisons = 0;

    // =====================================================================
    // Clocks; link clock offset so its edges never meet sys_clk edges
    always #2.5 sys_clk = ~sys_clk;
    initial begin
        #1.3;
        forever #16 mem_clk = mclk_en ? ~mem_clk : mem_clk;
    end

    csb_mbc_model mbc (.sys_clk_i(sys_clk), .mem_clk_i(mem_clk),
        .sel_n_o(sel_n), .rdy_n_o(rdy_n), .istb_o(istb), .ostb_o(ostb),
        .zbt_n_o(zbt_n), .eoc_n_o(eoc_n), .data_o(mdi));

    // Mode pin doubles as the memory clock, as in clocked systems
    csb_burst_top dut (.sys_clk_i(sys_clk), .rstn_i(rstn),
        .mem_clk_i(mem_clk), .strobed_mode_select_i(mem_clk),
        .mem_buffer_select_n_i(sel_n), .mem_ready_n_i(rdy_n),
        .mem_input_strobe_i(istb), .mem_output_strobe_i(ostb),
        .mem_output_latch_clock_i(1'b1), .zero_based_transfer_n_i(zbt_n),
        .mem_end_of_cycle_n_i(eoc_n), .mem_data_i(mdi),
        .burst_start_i(start), .eight_transfers_i(eight),
        .wb_buf_sel_i(wb_sel), .wb_wr_en_i(wb_en), .wb_wr_addr_i(wb_addr),
        .wb_wr_data_i(wb_data), .cyc_rd_addr_i(rd_addr), .mem_data_o(mdo),
        .cyc_rd_data_o(cyc_rd), .burst_ptr_o(bptr), .clocked_mode_o(cmode));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    task automatic sys_wait(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : sys_wait

    // Writeback buffer holds a0..a7 so each word names its slot
    task automatic wb_load;
        wb_en = 1'b1;
        for (int i = 0; i < 8; i++) begin
            wb_addr = i[2:0];
            wb_data = 8'ha0 + i[7:0];
            sys_wait(1);
        end
        wb_en = 1'b0;
    endtask : wb_load

    // Eight output edges from base 5 run past the line end
    task automatic t_ostb_burst;
        logic [2:0] idx;
        start = 3'h5;
        wb_sel = 1'b1;
        mbc.frame_start(1'b1);
        for (int k = 0; k < 8; k++) begin
            mbc.ostb_edge();
            idx = 3'h5 ^ k[2:0];
            check(mdo, 8'ha0 + {5'h0, idx});
            idx = 3'h5 ^ ((k == 7) ? 3'h7 : k[2:0] + 3'h1);
            check({5'h0, bptr}, {5'h0, idx});
        end
        mbc.frame_end();
        check({5'h0, bptr}, 8'h05);
        $display("test ostb burst done");
    endtask : t_ostb_burst

    // Input edges: ignored deselected, zero-based start, saturation at 3
    task automatic t_istb_zero;
        start = 3'h2;
        eight = 1'b0;
        wb_sel = 1'b0;
        mbc.istb_edge(8'h11);
        sys_wait(2);
        check({5'h0, bptr}, 8'h02);
        mbc.frame_start(1'b0);
        for (int k = 0; k < 4; k++) begin
            mbc.istb_edge(8'h30 + k[7:0]);
            check({5'h0, bptr}, (k == 3) ? 8'h03 : k[7:0] + 8'h01);
        end
        mbc.frame_end();
        check({5'h0, bptr}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rd_addr = i[2:0];
            sys_wait(2);
            check(cyc_rd, 8'h30 + i[7:0]);
        end
        $display("test istb zero-based done");
    endtask : t_istb_zero

    // End-of-cycle returns the pointer to base with select still held
    task automatic t_eoc;
        start = 3'h1;
        eight = 1'b1;
        mbc.frame_start(1'b1);
        mbc.ostb_edge();
        mbc.ostb_edge();
        check({5'h0, bptr}, 8'h03);
        mbc.eoc_pulse();
        check({5'h0, bptr}, 8'h01);
        mbc.frame_end();
        $display("test end-of-cycle done");
    endtask : t_eoc

    // Clocked mode after a second reset with the mode pin toggling
    task automatic t_clocked;
        int n;
        start = 3'h3;
        wb_sel = 1'b1;
        mclk_en = 1'b1;
        rstn = 1'b0;
        sys_wait(24);
        rstn = 1'b1;
        n = 0;
        while (cmode !== 1'b1 && n < 400) begin
            sys_wait(1);
            n++;
        end
        check({7'h0, cmode}, 8'h01);
        if (n >= 400) begin
            final_report();
        end
        repeat (5) mbc.beat(1'b1, 1'b1);
        repeat (2) mbc.beat(1'b1, 1'b0);
        repeat (4) mbc.beat(1'b1, 1'b1);
        // Before detection the block ran strobed and deselected, so the
        // pointer shows start 3; ignored ready must capture nothing
        check({5'h0, bptr}, 8'h03);
        repeat (3) mbc.beat(1'b0, 1'b0);
        repeat (4) mbc.beat(1'b1, 1'b1);
        check({5'h0, bptr}, 8'h01);
        check(mdo, 8'ha1);
        $display("test clocked mode done");
    endtask : t_clocked

    initial begin
        repeat (8) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        sys_wait(4);
        wb_load();
        t_ostb_burst();
        t_istb_zero();
        t_eoc();
        t_clocked();
        final_report();
    end
endmodule : cache_sram_memory_burst_counter_bench

`default_nettype wire
